//--- apf_top.sv
// protection and fault reporting for a four half-bridge power stage
`timescale 1ns/100ps
`include "apf_regs.svh"
// How it works
// - two active-low open-drain status outputs
// - alert low whenever a fault shuts down
// - warn low while above warning temperature
// - pin encoding: both high means normal
// - reset low forces alert high
// - fault tristates affected outputs, alert low
// - non-latched faults clear by themselves
// - mode table decides which halves stop
// - bootstrap undervoltage stops own half only
// - select code gives mode and threshold
// - invalid select gives minimum threshold
// - cycle limit flips half until frame
// - overload counter trips at maximum
// - latched mode stops on first event
// - overload shutdown holds until reset
// - pulse injection every fourth frame
// - clipping shown on warn, self clearing
// - clip pulse at least 500 ns
// - dc imbalance drives overload counter in cycle limit mode
// - dc protection off in single-ended
// - activity detector watches every output
// - thermal shutdown latches until reset
// - global faults: thermal latches until reset, undervoltage clears by itself
module apf_top
  import apf_pkg::*;
#(
  parameter int OL_W   = `APF_OL_W,
  parameter int OL_MAX = `APF_OL_MAX
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // pins from the analog sensors (asynchronous)
  input  wire logic        frame_start,
  input  wire logic [3:0]  oc_detect,
  input  wire logic [1:0]  dc_imbalance,
  input  wire logic [3:0]  boot_low,
  input  wire logic [3:0]  pwm_activity,
  input  wire logic        temp_warn,
  input  wire logic        temp_shutdown,
  input  wire logic        supply_low_protect,
  input  wire logic [1:0]  clip_detect,
  // power stage control
  output logic      [3:0]  half_bridge_hiz,
  output logic      [3:0]  half_bridge_flip,
  output logic      [3:0]  high_side_off,
  output logic             inject_pulse,
  output logic      [1:0]  current_threshold,
  output logic      [3:0]  activity_seen,
  // open-drain status pins, oe low drives low
  output logic             shutdown_alert_n_o,
  output logic             shutdown_alert_n_oe,
  output logic             clip_thermal_warn_n_o,
  output logic             clip_thermal_warn_n_oe
);
  import apf_pkg::*;

  localparam int SYNC_W = 1 + 4 + 2 + 4 + 4 + 1 + 1 + 1 + 2;
  localparam int CLIP_CYC_RAW = (`APF_CLIP_MIN_NS * `APF_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] CLIP_CYC = 8'(CLIP_CYC_RAW < 1 ? 1 : CLIP_CYC_RAW);

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
    logic              frame_prev;
    logic [3:0]        flip;
    logic [3:0]        oc_lat;
    logic [3:0]        ol_lat;
    logic              therm_lat;
    logic [1:0]        inj_cnt;
    logic              inject;
    logic [7:0]        clip_cnt;
    logic [3:0]        act;
    logic [3:0]        act_prev;
    logic [3:0]        hiz;
    logic              alert;
  } apf_st_t;
  apf_st_t s_q;
  apf_st_t s_d;

  logic [1:0]  cfg_mode;
  logic [2:0]  cfg_sel;
  logic [15:0] stat;
  apf_mode_t   mode;
  apf_ocmode_t ocmode;
  logic [1:0]  ol_trip;
  logic [2:0]  oc_dec;

  // synchronised views of the asynchronous pins
  logic        fr_s;
  logic [3:0]  oc_s;
  logic [1:0]  dc_s;
  logic [3:0]  bt_s;
  logic [3:0]  pa_s;
  logic        tw_s;
  logic        ts_s;
  logic        uv_s;
  logic [1:0]  cl_s;
  assign {fr_s, oc_s, dc_s, bt_s, pa_s, tw_s, ts_s, uv_s, cl_s} = s_q.s2;

  // select code to mode and threshold; invalid codes fall to minimum
  function automatic logic [2:0] apf_decode(input logic [2:0] sel);
    logic [2:0] r;
    r = {1'b0, `APF_THR_MIN};
    if (sel >= `APF_SEL_CB_LO && sel <= `APF_SEL_CB_HI) begin
      r = {1'b0, sel[1:0]};
    end else if (sel >= `APF_SEL_LT_LO && sel <= `APF_SEL_LT_HI) begin
      r = {1'b1, sel[1:0]};
    end
    return r;
  endfunction

  // unknown mode code behaves as bridged
  always_comb begin
    case (cfg_mode)
      2'h1:    mode = APF_MODE_PARALLEL;
      2'h2:    mode = APF_MODE_SINGLE;
      default: mode = APF_MODE_BRIDGED;
    endcase
  end
  // decode once; a select on a call result is not portable
  assign oc_dec            = apf_decode(cfg_sel);
  assign ocmode            = oc_dec[2] ? APF_OC_LATCHED : APF_OC_CYCLE;
  assign current_threshold = oc_dec[1:0];

  wire frame_tick = fr_s && !s_q.frame_prev;
  wire cyc_mode   = (ocmode == APF_OC_CYCLE);

  // per bridge counters, each fed by its two halves
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : gen_ch
      apf_ch_if chi ();
      assign chi.frame_tick = frame_tick;
      assign chi.oc_event   = |oc_s[2*g +: 2];
      assign chi.dc_event   = dc_s[g] && (mode != APF_MODE_SINGLE);
      assign chi.count_en   = cyc_mode;
      assign ol_trip[g]     = chi.ol_trip;
      apf_ol_counter #(.W(OL_W), .MAX(OL_MAX)) u_cnt (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .clr      (1'b0),
        .ch       (chi.cnt)
      );
    end
  endgenerate

  // mode table: a fault group to the halves it stops
  function automatic logic [3:0] apf_spread(input logic [3:0] f, input apf_mode_t m);
    logic [3:0] r;
    r = '0;
    if (m == APF_MODE_PARALLEL) begin
      r = {4{|f}};
    end else begin
      r = {{2{|f[3:2]}}, {2{|f[1:0]}}};
    end
    return r;
  endfunction

  // protection state update
  always_comb begin
    logic [3:0] ch_fault;
    logic       glob;
    s_d = s_q;
    ch_fault = '0;
    glob = 1'b0;
    s_d.s1 = {frame_start, oc_detect, dc_imbalance, boot_low, pwm_activity,
              temp_warn, temp_shutdown, supply_low_protect, clip_detect};
    s_d.s2 = s_q.s1;
    s_d.frame_prev = fr_s;

    // flip held until the next frame, per half
    if (frame_tick) begin
      s_d.flip = '0;
    end
    if (cyc_mode) begin
      s_d.flip = s_d.flip | oc_s;
    end else begin
      s_d.oc_lat = s_q.oc_lat | oc_s;
    end
    s_d.ol_lat = s_q.ol_lat | {{2{ol_trip[1]}}, {2{ol_trip[0]}}};
    s_d.therm_lat = s_q.therm_lat | ts_s;

    ch_fault = s_d.oc_lat | s_d.ol_lat;
    glob = s_d.therm_lat || uv_s;
    s_d.hiz = glob ? 4'hf : apf_spread(ch_fault, mode);
    s_d.alert = glob || (|ch_fault);

    // narrow pulse every fourth frame while saturated
    s_d.inject = 1'b0;
    if (frame_tick) begin
      if ((|cl_s) || (cyc_mode && (|s_q.flip))) begin
        s_d.inj_cnt = s_q.inj_cnt + 2'h1;
        s_d.inject  = (s_q.inj_cnt == 2'(`APF_INJ_PERIOD - 1));
      end else begin
        s_d.inj_cnt = '0;
      end
    end

    // clip indication stretched to a minimum width, follows longer clipping
    if (|cl_s) begin
      s_d.clip_cnt = CLIP_CYC;
    end else if (s_q.clip_cnt != 8'h00) begin
      s_d.clip_cnt = s_q.clip_cnt - 8'h01;
    end

    // activity: any toggle of a half's output seen since last frame
    s_d.act_prev = pa_s;
    if (frame_tick) begin
      s_d.act = pa_s ^ s_q.act_prev;
    end else begin
      s_d.act = s_q.act | (pa_s ^ s_q.act_prev);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs
  assign half_bridge_hiz  = s_q.hiz;
  assign half_bridge_flip = s_q.flip & ~s_q.hiz;
  assign high_side_off    = bt_s;
  assign inject_pulse     = s_q.inject;
  assign activity_seen    = s_q.act;

  // open-drain: oe low pulls the pin low, pull-up makes high
  assign shutdown_alert_n_o     = 1'b0;
  assign shutdown_alert_n_oe    = !(s_q.alert && rst_n);
  assign clip_thermal_warn_n_o  = 1'b0;
  assign clip_thermal_warn_n_oe = !(tw_s || (s_q.clip_cnt != 8'h00));

  assign stat = {2'h0, s_q.act, s_q.therm_lat, uv_s, tw_s, s_q.alert, s_q.hiz, s_q.ol_lat[2], s_q.ol_lat[0]};

  apf_wb_slave u_wb (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_dat_i (wb_dat_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .cfg_mode (cfg_mode),
    .cfg_sel  (cfg_sel),
    .stat     (stat)
  );
endmodule

//--- apf_regs.svh
// constants for the amplifier protection and fault logic
`ifndef APF_REGS_SVH
`define APF_REGS_SVH
`define APF_CLK_MHZ        250
`define APF_CLIP_MIN_NS    500
`define APF_CLIP_MIN_CYC   ((`APF_CLIP_MIN_NS * `APF_CLIP_MIN_MHZ_DIV + 999) / 1000)
`define APF_CLIP_MIN_MHZ_DIV `APF_CLK_MHZ
`define APF_INJ_PERIOD     4
`define APF_OL_MAX         15
`define APF_OL_W           4
`define APF_SEL_CB_LO      3'h0
`define APF_SEL_CB_HI      3'h3
`define APF_SEL_LT_LO      3'h4
`define APF_SEL_LT_HI      3'h7
`define APF_THR_17A0       2'h0
`define APF_THR_15A7       2'h1
`define APF_THR_14A2       2'h2
`define APF_THR_12A9       2'h3
`define APF_THR_MIN        `APF_THR_12A9
`define APF_WB_ADDR_CFG    8'h00
`define APF_WB_ADDR_STAT   8'h04
`define APF_WB_ADDR_LATCH  8'h08
`endif

//--- apf_pkg.sv
// types shared by the amplifier protection and fault logic
package apf_pkg;
  typedef enum logic [1:0] {
    APF_MODE_BRIDGED,
    APF_MODE_PARALLEL,
    APF_MODE_SINGLE
  } apf_mode_t;
  typedef enum logic {
    APF_OC_CYCLE,
    APF_OC_LATCHED
  } apf_ocmode_t;
endpackage

//--- apf_ch_if.sv
// per bridged channel event/status bundle between top and the channel counter
`timescale 1ns/100ps
interface apf_ch_if;
  logic       frame_tick;
  logic       oc_event;
  logic       dc_event;
  logic       count_en;
  logic       ol_trip;
  modport top (output frame_tick, output oc_event, output dc_event, output count_en, input ol_trip);
  modport cnt (input frame_tick, input oc_event, input dc_event, input count_en, output ol_trip);
endinterface

//--- apf_ol_counter.sv
// up/down overload counter for one bridged channel
`timescale 1ns/100ps
`include "apf_regs.svh"
module apf_ol_counter #(
  parameter int W   = `APF_OL_W,
  parameter int MAX = `APF_OL_MAX
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clr,
  // channel events
  apf_ch_if.cnt    ch
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         trip;
    logic         hit;
  } apf_olc_st_t;
  apf_olc_st_t s_q;
  apf_olc_st_t s_d;

  // hits pend within a frame, the frame tick settles them
  always_comb begin
    s_d = s_q;
    if (ch.count_en && (ch.oc_event || ch.dc_event)) begin
      s_d.hit = 1'b1;
    end
    if (ch.frame_tick) begin
      s_d.hit = 1'b0;
      if (s_q.hit || (ch.count_en && (ch.oc_event || ch.dc_event))) begin
        if (s_q.cnt != W'(MAX)) begin
          s_d.cnt = s_q.cnt + W'(1);
        end
      end else if (s_q.cnt != '0) begin
        s_d.cnt = s_q.cnt - W'(1);
      end
    end
    if (s_q.cnt == W'(MAX)) begin
      s_d.trip = 1'b1;
    end
    if (clr) begin
      s_d = '0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch.ol_trip = s_q.trip;
endmodule

//--- apf_wb_slave.sv
// classic wishbone register slave: config in, status out
`timescale 1ns/100ps
`include "apf_regs.svh"
module apf_wb_slave (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // wishbone
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // block side
  output logic      [1:0]  cfg_mode,
  output logic      [2:0]  cfg_sel,
  input  wire logic [15:0] stat
);
  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
    logic [1:0]  mode;
    logic [2:0]  sel;
  } apf_wb_st_t;
  apf_wb_st_t s_q;
  apf_wb_st_t s_d;

  // one-wait answer; ack drops the cycle after it was given
  always_comb begin
    s_d     = s_q;
    s_d.ack = 1'b0;
    if (wb_cyc_i && wb_stb_i && !s_q.ack) begin
      s_d.ack = 1'b1;
      s_d.dat = 32'h0000_0000;
      case (wb_adr_i)
        `APF_WB_ADDR_CFG: begin
          if (wb_we_i && wb_sel_i[0]) begin
            s_d.mode = wb_dat_i[1:0];
            s_d.sel  = wb_dat_i[4:2];
          end
          s_d.dat = {27'h000_0000, s_q.sel, s_q.mode};
        end
        `APF_WB_ADDR_STAT: s_d.dat = {16'h0000, stat};
        default: s_d.dat = 32'h0000_0000; // unmapped reads zero, writes dropped
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.dat;
  assign cfg_mode = s_q.mode;
  assign cfg_sel  = s_q.sel;
endmodule

//--- apf_top_chk.sv
// port checker for the protection and fault logic
`timescale 1ns/100ps
`include "apf_regs.svh"
module apf_top_chk #(
  parameter int OL_W   = `APF_OL_W,
  parameter int OL_MAX = `APF_OL_MAX
) (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // sensors
  input wire logic       temp_warn,
  input wire logic       temp_shutdown,
  input wire logic       supply_low_protect,
  input wire logic [3:0] boot_low,
  // stage and pins
  input wire logic [3:0] half_bridge_hiz,
  input wire logic [3:0] high_side_off,
  input wire logic       inject_pulse,
  input wire logic       shutdown_alert_n_o,
  input wire logic       shutdown_alert_n_oe,
  input wire logic       clip_thermal_warn_n_o,
  input wire logic       clip_thermal_warn_n_oe
);
  logic [7:0] lo_q;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // length of the current low stretch on the warn pin, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) lo_q <= '0;
    else if (clip_thermal_warn_n_oe) lo_q <= '0;
    else if (lo_q != 8'hff) lo_q <= lo_q + 8'h01;
  end
  property p_od; !shutdown_alert_n_o && !clip_thermal_warn_n_o; endproperty
  a_od: assert property (p_od) else $error("status pin drives high");
  property p_rst; $rose(rst_n) |-> shutdown_alert_n_oe; endproperty
  a_rst: assert property (p_rst) else $error("alert low out of reset");
  property p_ote; $rose(temp_shutdown) |-> ##[1:4] (!shutdown_alert_n_oe && half_bridge_hiz == 4'hf); endproperty
  a_ote: assert property (p_ote) else $error("thermal shutdown not shown");
  property p_uv; $rose(supply_low_protect) |-> ##[1:4] (!shutdown_alert_n_oe && half_bridge_hiz == 4'hf); endproperty
  a_uv: assert property (p_uv) else $error("undervoltage not shown");
  property p_warn; temp_warn [*5] |-> !clip_thermal_warn_n_oe; endproperty
  a_warn: assert property (p_warn) else $error("warning not shown");
  property p_pair; half_bridge_hiz[0] == half_bridge_hiz[1] && half_bridge_hiz[2] == half_bridge_hiz[3]; endproperty
  a_pair: assert property (p_pair) else $error("half bridges split");
  property p_boot; $rose(boot_low[0]) |-> ##[1:3] high_side_off[0]; endproperty
  a_boot: assert property (p_boot) else $error("high side stays on");
  property p_inj; inject_pulse |=> !inject_pulse [*3]; endproperty
  a_inj: assert property (p_inj) else $error("injection too dense");
  property p_clip; $rose(clip_thermal_warn_n_oe) |-> lo_q >= 8'd125; endproperty
  a_clip: assert property (p_clip) else $error("warn low too short");
  property p_ack; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus answer late or long");
  c_inj: cover property (inject_pulse);
  c_alert: cover property (!shutdown_alert_n_oe);
  c_warn: cover property ($fell(clip_thermal_warn_n_oe));
endmodule
bind apf_top apf_top_chk #(.OL_W(OL_W), .OL_MAX(OL_MAX)) i_chk (
  .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .temp_warn(temp_warn), .temp_shutdown(temp_shutdown), .supply_low_protect(supply_low_protect),
  .boot_low(boot_low), .half_bridge_hiz(half_bridge_hiz), .high_side_off(high_side_off),
  .inject_pulse(inject_pulse), .shutdown_alert_n_o(shutdown_alert_n_o),
  .shutdown_alert_n_oe(shutdown_alert_n_oe), .clip_thermal_warn_n_o(clip_thermal_warn_n_o),
  .clip_thermal_warn_n_oe(clip_thermal_warn_n_oe));

//--- apf_mcu_model.sv
// controller side: pull-ups on the status pins and volume reaction
`timescale 1ns/100ps
module apf_mcu_model (
  // open-drain drivers
  input wire logic alert_o,
  input wire logic alert_oe,
  input wire logic warn_o,
  input wire logic warn_oe,
  // resolved pins and reaction
  output logic     alert_pin,
  output logic     warn_pin,
  output logic     vol_down
);
  // pull-up wins whenever the driver is off
  assign alert_pin = alert_oe ? 1'b1 : alert_o;
  assign warn_pin  = warn_oe ? 1'b1 : warn_o;
  // lower volume on a warning, before shutdown hits
  assign vol_down  = !warn_pin;
endmodule

//--- apf_top_bench.sv
// self-checking bench for the protection and fault logic
`timescale 1ns/100ps
`include "apf_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module apf_top_bench;
  logic core_clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, frame_start = 0;
  logic [7:0] wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic [3:0] wb_sel_i = 4'hf, oc_detect = '0, boot_low = '0, pwm_activity = '0;
  logic [1:0] dc_imbalance = '0, clip_detect = '0, current_threshold;
  logic temp_warn = 0, temp_shutdown = 0, supply_low_protect = 0, wb_ack_o, inject_pulse;
  logic [3:0] hiz, flip, high_side_off, activity_seen;
  logic a_o, a_oe, w_o, w_oe, a_pin, w_pin, vol_dn;
  int errors = 0, n_tests = 0, cyc = 0, n_inj = 0;
  logic [3:0] exp_hiz [3] = '{4'b1100, 4'hf, 4'b1100};
  apf_top #(.OL_W(4), .OL_MAX(15)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_start(frame_start), .oc_detect(oc_detect),
    .dc_imbalance(dc_imbalance), .boot_low(boot_low), .pwm_activity(pwm_activity), .temp_warn(temp_warn),
    .temp_shutdown(temp_shutdown), .supply_low_protect(supply_low_protect), .clip_detect(clip_detect),
    .half_bridge_hiz(hiz), .half_bridge_flip(flip), .high_side_off(high_side_off),
    .inject_pulse(inject_pulse), .current_threshold(current_threshold), .activity_seen(activity_seen),
    .shutdown_alert_n_o(a_o), .shutdown_alert_n_oe(a_oe), .clip_thermal_warn_n_o(w_o),
    .clip_thermal_warn_n_oe(w_oe));
  apf_mcu_model i_mcu (.alert_o(a_o), .alert_oe(a_oe), .warn_o(w_o), .warn_oe(w_oe),
    .alert_pin(a_pin), .warn_pin(w_pin), .vol_down(vol_dn));
  always #2 core_clk = ~core_clk;
  // hang guard and injection counter
  always @(posedge core_clk) begin
    cyc++;
    if (inject_pulse === 1'b1) n_inj++;
    if (cyc == 20000) begin
      errors++;
      finish_test();
    end
  end
  task automatic tick(int n); repeat (n) @(posedge core_clk); endtask
  // controller toggles reset to clear latched faults
  task automatic rst(); rst_n <= 0; tick(3); rst_n <= 1; tick(2); endtask
  task automatic frames(int n);
    repeat (n) begin
      frame_start <= 1; tick(8); frame_start <= 0; tick(8);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o; wb_cyc_i <= 0; wb_stb_i <= 0; tick(1);
  endtask
  task automatic t_regs();
    wb(0, `APF_WB_ADDR_CFG, 0); `CHK(rd, 32'h0000_0000);
    wb(0, 8'h0c, 0); `CHK(rd, 32'h0000_0000);
    for (int s = 0; s < 8; s++) begin
      wb(1, `APF_WB_ADDR_CFG, s << 2); `CHK(current_threshold, 2'(s));
    end
  endtask
  task automatic t_uv();
    supply_low_protect <= 1; tick(8);
    `CHK(a_pin, 1'b0); `CHK(w_pin, 1'b1); `CHK(hiz, 4'hf);
    wb(0, `APF_WB_ADDR_STAT, 0); `CHK(rd[8], 1'b1);
    supply_low_protect <= 0; tick(8); `CHK(a_pin, 1'b1); `CHK(hiz, 4'h0);
    boot_low <= 4'b0010; tick(8);
    `CHK(high_side_off, 4'b0010); `CHK(hiz, 4'h0); `CHK(a_pin, 1'b1);
    boot_low <= 0; tick(4);
  endtask
  task automatic t_therm();
    temp_warn <= 1; tick(140); `CHK(w_pin, 1'b0); `CHK(a_pin, 1'b1); `CHK(vol_dn, 1'b1);
    temp_shutdown <= 1; tick(8); `CHK(a_pin, 1'b0); `CHK(hiz, 4'hf);
    temp_shutdown <= 0; temp_warn <= 0; tick(8); `CHK(a_pin, 1'b0);
    supply_low_protect <= 1; rst_n <= 0; tick(3); `CHK(a_pin, 1'b1);
    supply_low_protect <= 0; rst_n <= 1; tick(8); `CHK(a_pin, 1'b1); `CHK(hiz, 4'h0);
  endtask
  task automatic t_latch();
    for (int m = 0; m < 3; m++) begin
      rst(); wb(1, `APF_WB_ADDR_CFG, 32'h10 | m);
      oc_detect <= 4'h4; tick(4); oc_detect <= 0; tick(8);
      `CHK(hiz, exp_hiz[m]); `CHK(a_pin, 1'b0);
    end
    frames(2); `CHK(hiz, 4'b1100);
    rst(); `CHK(hiz, 4'h0);
  endtask
  task automatic t_cycle();
    wb(1, `APF_WB_ADDR_CFG, 0); oc_detect <= 4'h1; tick(6); `CHK(flip, 4'h1);
    oc_detect <= 0; frames(2); `CHK(flip, 4'h0); `CHK(hiz, 4'h0);
    oc_detect <= 4'h1; tick(4); n_inj = 0; frames(8); `CHK(n_inj, 2);
    frames(12); `CHK(hiz, 4'h3); `CHK(a_pin, 1'b0);
    oc_detect <= 0; frames(2); `CHK(hiz, 4'h3);
  endtask
  task automatic t_dc();
    rst(); wb(1, `APF_WB_ADDR_CFG, 2); dc_imbalance <= 2'b01; frames(20); `CHK(hiz, 4'h0);
    rst(); frames(20); `CHK(hiz, 4'h3); `CHK(a_pin, 1'b0);
    dc_imbalance <= 0; rst();
  endtask
  task automatic t_misc();
    clip_detect <= 2'b01; tick(2); clip_detect <= 0; tick(6); `CHK(w_pin, 1'b0);
    tick(100); `CHK(w_pin, 1'b0);
    tick(200); `CHK(w_pin, 1'b1);
    repeat (8) begin pwm_activity <= ~pwm_activity; tick(2); end
    tick(4); `CHK(activity_seen, 4'hf);
  endtask
  task automatic finish_test();
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    tick(3); rst_n <= 1; tick(1);
    t_regs(); t_uv(); t_therm(); t_latch(); t_cycle(); t_dc(); t_misc();
    finish_test();
  end
endmodule
